// [rtl/blsc_ctrl.sv]
// button and indicator state controller of the measurement unit
// Function
// - when off, a single press powers up and enters network search
// - search blinks LED rapidly; established host link lights LED steady
// - single press while sweep enabled pauses and blocks measurement triggers
// - paused state flashes LED once every 3 seconds
// - paused longer than 15 minutes powers off; single press restarts
// - single press while paused returns to sweep enabled
// - connected and sweep enabled keeps LED steadily lit
// - host link loss while sweep enabled returns to search with rapid blinking
// - five rapid presses enter re-pairing with groups of five flashes
// - sensor also gets five presses; flashing groups continue until paired
// - button held 5 seconds then released performs a reset
// - all host and sensor traffic is relayed through this unit
// - charging while off blinks slowly, steady when full, measurements inhibited
`default_nettype none
module blsc_ctrl
  import blsc_pkg::*;
#(
  parameter longint unsigned PAUSE_OFF_CYCLES = PAUSE_OFF_CYC,
  parameter longint unsigned HOLD_CYCLES      = HOLD_CYC,
  parameter longint unsigned PFLASH_CYCLES    = PFLASH_CYC,
  parameter longint unsigned GROUP_CYCLES     = GROUP_CYC,
  parameter longint unsigned DEB_CYCLES       = DEB_CYC,
  parameter longint unsigned FAST_CYCLES      = FAST_CYC,
  parameter longint unsigned SLOW_CYCLES      = SLOW_CYC,
  parameter longint unsigned FLON_CYCLES      = FLON_CYC,
  parameter longint unsigned GAP_CYCLES       = GAP_CYC
)(
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic              button,
  input  wire logic              host_link,
  input  wire logic              charging,
  input  wire logic              charge_full,
  input  wire logic              pair_done,
  input  wire logic              host_meas_req,
  input  wire blsc_pkg::blsc_msg_s host_rx,
  input  wire blsc_pkg::blsc_msg_s sensor_rx,
  output logic                   led,
  output logic                   power_en,
  output logic                   unit_reset,
  output logic                   meas_trigger,
  output logic                   pair_start,
  output blsc_pkg::blsc_state_e  state,
  output blsc_pkg::blsc_msg_s    host_tx,
  output blsc_pkg::blsc_msg_s    sensor_tx
);
  import blsc_pkg::*;

  localparam logic [CW-1:0] PAUSE_OFF_N = CW'(PAUSE_OFF_CYCLES);
  localparam logic [CW-1:0] HOLD_N      = CW'(HOLD_CYCLES);
  localparam logic [CW-1:0] PFLASH_N    = CW'(PFLASH_CYCLES);
  localparam logic [CW-1:0] GROUP_N     = CW'(GROUP_CYCLES);
  localparam logic [CW-1:0] DEB_N       = CW'(DEB_CYCLES);
  localparam logic [CW-1:0] FAST_N      = CW'(FAST_CYCLES);
  localparam logic [CW-1:0] SLOW_N      = CW'(SLOW_CYCLES);
  localparam logic [CW-1:0] FLON_N      = CW'(FLON_CYCLES);
  localparam logic [CW-1:0] GAP_N       = CW'(GAP_CYCLES);
  localparam logic [3:0]    N_OFF       = 4'(OFF_PRESSES);
  localparam logic [3:0]    N_PAIR      = 4'(PAIR_PRESSES);
  localparam logic [3:0]    N_FLASH     = 4'(PAIR_FLASHES);

  blsc_reg_s r_q;
  blsc_reg_s r_d;

  logic press_ev;
  logic release_ev;
  logic group_done;
  logic single_p;
  logic triple_p;
  logic five_p;

  always_comb
  begin
    r_d            = r_q;
    r_d.rst_pulse  = 1'b0;
    r_d.meas_go    = 1'b0;
    r_d.pair_go    = 1'b0;
    press_ev       = 1'b0;
    release_ev     = 1'b0;
    // debounce: a level change must stay stable for the whole filter time
    if (button != r_q.btn_q)
    begin
      if (r_q.deb_cnt >= DEB_N - 1'b1)
      begin
        r_d.btn_q   = button;
        r_d.deb_cnt = '0;
        press_ev    = button;
        release_ev  = ~button;
      end
      else
        r_d.deb_cnt = r_q.deb_cnt + 1'b1;
    end
    else
      r_d.deb_cnt = '0;

    // long hold detection; a long hold never counts as a press
    if (press_ev)
    begin
      r_d.hold_cnt  = '0;
      r_d.held_long = 1'b0;
    end
    else if (r_q.btn_q && !r_q.held_long)
    begin
      if (r_q.hold_cnt >= HOLD_N - 1'b1)
        r_d.held_long = 1'b1;
      else
        r_d.hold_cnt = r_q.hold_cnt + 1'b1;
    end

    // press grouping window restarts on every press
    group_done = 1'b0;
    if (press_ev)
    begin
      r_d.presses = (r_q.presses == 4'hf) ? r_q.presses : r_q.presses + 1'b1;
      r_d.grp_cnt = '0;
    end
    else if (r_q.presses != PRESS_RST && !r_q.btn_q)
    begin
      if (r_q.grp_cnt >= GROUP_N - 1'b1)
      begin
        group_done  = 1'b1;
        r_d.presses = PRESS_RST;
        r_d.grp_cnt = '0;
      end
      else
        r_d.grp_cnt = r_q.grp_cnt + 1'b1;
    end
    single_p = group_done && r_q.presses == 4'h1 && !r_q.held_long;
    triple_p = group_done && r_q.presses == N_OFF;
    five_p   = group_done && r_q.presses == N_PAIR;

    r_d.led_cnt = r_q.led_cnt + 1'b1;
    r_d.idle_cnt = '0;

    case (r_q.st)
      ST_OFF:
      begin
        r_d.power = 1'b0;
        r_d.led   = 1'b0;
        if (charging)
          r_d.st = ST_CHARGE;
        else if (single_p)
        begin
          r_d.st    = ST_SEARCH;
          r_d.power = 1'b1;
        end
      end
      ST_SEARCH:
      begin
        if (r_q.led_cnt >= FAST_N - 1'b1)
        begin
          r_d.led     = ~r_q.led;
          r_d.led_cnt = '0;
        end
        if (host_link)
        begin
          r_d.st  = ST_SWEEP;
          r_d.led = 1'b1;
        end
      end
      ST_SWEEP:
      begin
        r_d.led = 1'b1;
        if (!host_link)
          r_d.st = ST_SEARCH;
        else if (single_p)
          r_d.st = ST_PAUSED;
        else if (host_meas_req)
          r_d.meas_go = 1'b1;
      end
      ST_PAUSED:
      begin
        // flash briefly at the start of each 3 s frame
        r_d.led = (r_q.led_cnt < FLON_N);
        if (r_q.led_cnt >= PFLASH_N - 1'b1)
          r_d.led_cnt = '0;
        r_d.idle_cnt = r_q.idle_cnt + 1'b1;
        if (r_q.idle_cnt >= PAUSE_OFF_N)
          r_d.st = ST_OFF;
        else if (single_p)
          r_d.st = ST_SWEEP;
      end
      ST_PAIR:
      begin
        // five short flashes then a long dark gap, until pairing ends
        if (r_q.flash_no < N_FLASH)
        begin
          r_d.led = (r_q.led_cnt < FLON_N);
          if (r_q.led_cnt >= (FLON_N << 1) - 1'b1)
          begin
            r_d.led_cnt  = '0;
            r_d.flash_no = r_q.flash_no + 1'b1;
          end
        end
        else
        begin
          r_d.led = 1'b0;
          if (r_q.led_cnt >= GAP_N - 1'b1)
          begin
            r_d.led_cnt  = '0;
            r_d.flash_no = '0;
          end
        end
        if (pair_done)
          r_d.st = host_link ? ST_SWEEP : ST_SEARCH;
      end
      ST_CHARGE:
      begin
        if (charge_full)
          r_d.led = 1'b1;
        else if (r_q.led_cnt >= SLOW_N - 1'b1)
        begin
          r_d.led     = ~r_q.led;
          r_d.led_cnt = '0;
        end
        if (!charging)
          r_d.st = r_q.power ? ST_SEARCH : ST_OFF;
      end
      default:
        r_d.st = ST_OFF;
    endcase

    // bursts that apply in every powered state
    if (r_q.st != ST_OFF && r_q.st != ST_CHARGE)
    begin
      if (triple_p)
      begin
        r_d.st    = ST_OFF;
        r_d.power = 1'b0;
        r_d.led   = 1'b0;
      end
      else if (five_p)
      begin
        r_d.st       = ST_PAIR;
        r_d.pair_go  = 1'b1;
        r_d.flash_no = '0;
        r_d.led_cnt  = '0;
      end
    end
    if (r_d.st != r_q.st && r_d.st != ST_PAIR)
      r_d.led_cnt = '0;

    // long hold then release resets the unit and, when powered, restarts the search
    if (release_ev && r_q.held_long)
    begin
      r_d.rst_pulse = 1'b1;
      r_d.held_long = 1'b0;
      r_d.presses   = PRESS_RST;
      if (r_q.power)
        r_d.st = ST_SEARCH;
    end

    // relay: this unit is the only path between host and sensor
    r_d.to_sensor = host_rx;
    r_d.to_host   = sensor_rx;
  end
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      r_q <= '0; // all zero is ST_OFF with power released
    else
      r_q <= r_d;
  end

  assign led          = r_q.led;
  assign power_en     = r_q.power;
  assign unit_reset   = r_q.rst_pulse;
  assign meas_trigger = r_q.meas_go;
  assign pair_start   = r_q.pair_go;
  assign state        = r_q.st;
  assign host_tx      = r_q.to_host;
  assign sensor_tx    = r_q.to_sensor;
  sequence s_sweep_req;
    r_q.st == ST_SWEEP && host_link && !single_p && !triple_p && !five_p && host_meas_req;
  endsequence
  property p_off_wake;
    @(posedge mclk) disable iff (!resetn)
    r_q.st == ST_OFF && !charging && single_p |=> r_q.st == ST_SEARCH && r_q.power;
  endproperty
  a_off_wake: assert property (p_off_wake) else $error("single press did not wake unit");
  property p_link_steady;
    @(posedge mclk) disable iff (!resetn)
    r_q.st == ST_SWEEP && host_link && !triple_p |=> led;
  endproperty
  a_link_steady: assert property (p_link_steady) else $error("led not steady while connected");
  property p_pause;
    @(posedge mclk) disable iff (!resetn)
    r_q.st == ST_SWEEP && host_link && single_p && !release_ev |=> r_q.st == ST_PAUSED ##1 !meas_trigger;
  endproperty
  a_pause: assert property (p_pause) else $error("press in sweep did not pause");
  property p_meas_only_sweep;
    @(posedge mclk) disable iff (!resetn)
    meas_trigger |-> $past(r_q.st) == ST_SWEEP;
  endproperty
  a_meas_only_sweep: assert property (p_meas_only_sweep) else $error("measurement outside sweep");
  property p_meas_go;
    @(posedge mclk) disable iff (!resetn)
    s_sweep_req |=> meas_trigger;
  endproperty
  a_meas_go: assert property (p_meas_go) else $error("sweep request not honoured");
  property p_link_loss;
    @(posedge mclk) disable iff (!resetn)
    r_q.st == ST_SWEEP && !host_link && !triple_p && !five_p && !release_ev |=> r_q.st == ST_SEARCH;
  endproperty
  a_link_loss: assert property (p_link_loss) else $error("link loss not handled");
  property p_triple_off;
    @(posedge mclk) disable iff (!resetn)
    triple_p && r_q.st != ST_OFF && r_q.st != ST_CHARGE && !release_ev |=> !power_en && r_q.st == ST_OFF;
  endproperty
  a_triple_off: assert property (p_triple_off) else $error("triple press did not power off");
  property p_five_pair;
    @(posedge mclk) disable iff (!resetn)
    five_p && r_q.st != ST_OFF && r_q.st != ST_CHARGE && !release_ev |=> r_q.st == ST_PAIR && pair_start;
  endproperty
  a_five_pair: assert property (p_five_pair) else $error("five presses did not start pairing");
  property p_hold_reset;
    @(posedge mclk) disable iff (!resetn)
    release_ev && r_q.held_long |=> unit_reset ##1 !unit_reset;
  endproperty
  a_hold_reset: assert property (p_hold_reset) else $error("long hold release gave no reset pulse");
  property p_relay;
    @(posedge mclk) disable iff (!resetn)
    1'b1 |=> host_tx == $past(sensor_rx) && sensor_tx == $past(host_rx);
  endproperty
  a_relay: assert property (p_relay) else $error("relay path broken");
  property p_charge_full;
    @(posedge mclk) disable iff (!resetn)
    r_q.st == ST_CHARGE && charge_full |=> led && !meas_trigger;
  endproperty
  a_charge_full: assert property (p_charge_full) else $error("charge indication wrong");
endmodule : blsc_ctrl
`default_nettype wire

// [rtl/blsc_pkg.sv]
// package of constants and types for the button and indicator state controller
`default_nettype none
package blsc_pkg;
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned PAUSE_OFF_MIN   = 15;
  localparam int unsigned HOLD_RESET_S    = 5;
  localparam int unsigned PAUSE_FLASH_S   = 3;
  localparam int unsigned GROUP_WIN_MS    = 400;
  localparam int unsigned DEBOUNCE_MS     = 10;
  localparam int unsigned FAST_BLINK_MS   = 100;
  localparam int unsigned SLOW_BLINK_MS   = 500;
  localparam int unsigned FLASH_ON_MS     = 100;
  localparam int unsigned PAIR_GAP_MS     = 1000;
  localparam int unsigned PAIR_FLASHES    = 5;
  localparam int unsigned OFF_PRESSES     = 3;
  localparam int unsigned PAIR_PRESSES    = 5;
  // cycle counts derived from the times above
  localparam longint unsigned PAUSE_OFF_CYC = longint'(PAUSE_OFF_MIN) * 60 * CLK_HZ;
  localparam longint unsigned HOLD_CYC      = longint'(HOLD_RESET_S) * CLK_HZ;
  localparam longint unsigned PFLASH_CYC    = longint'(PAUSE_FLASH_S) * CLK_HZ;
  localparam longint unsigned GROUP_CYC     = longint'(GROUP_WIN_MS) * (CLK_HZ / 1000);
  localparam longint unsigned DEB_CYC       = longint'(DEBOUNCE_MS) * (CLK_HZ / 1000);
  localparam longint unsigned FAST_CYC      = longint'(FAST_BLINK_MS) * (CLK_HZ / 1000);
  localparam longint unsigned SLOW_CYC      = longint'(SLOW_BLINK_MS) * (CLK_HZ / 1000);
  localparam longint unsigned FLON_CYC      = longint'(FLASH_ON_MS) * (CLK_HZ / 1000);
  localparam longint unsigned GAP_CYC       = longint'(PAIR_GAP_MS) * (CLK_HZ / 1000);
  localparam int unsigned CW = 36;
  localparam logic [3:0] PRESS_RST = 4'h0;

  typedef enum logic [2:0] {ST_OFF, ST_SEARCH, ST_PAUSED, ST_SWEEP, ST_PAIR, ST_CHARGE} blsc_state_e;

  typedef struct packed {
    logic       req;
    logic [7:0] data;
  } blsc_msg_s;

  typedef struct packed {
    blsc_state_e     st;
    logic            btn_q;
    logic [CW-1:0]   deb_cnt;
    logic [CW-1:0]   hold_cnt;
    logic            held_long;
    logic [3:0]      presses;
    logic [CW-1:0]   grp_cnt;
    logic [CW-1:0]   idle_cnt;
    logic [CW-1:0]   led_cnt;
    logic [3:0]      flash_no;
    logic            led;
    logic            power;
    logic            rst_pulse;
    logic            meas_go;
    logic            pair_go;
    blsc_msg_s       to_host;
    blsc_msg_s       to_sensor;
  } blsc_reg_s;
endpackage : blsc_pkg
`default_nettype wire

// [dv/blsc_far_model.sv]
// far side model: operator at the pushbutton and the paired sensor unit
`default_nettype none
module blsc_far_model
  import blsc_pkg::*;
#(
  parameter int HOLD_LEN = 60
)(
  input  wire logic                mclk,
  input  wire logic                resetn,
  input  wire logic                go,
  input  wire logic [3:0]          n_press,
  input  wire logic                hold,
  output var  logic                busy,
  output var  logic                button,
  input  wire logic                pair_start,
  output var  logic                pair_done,
  input  wire blsc_pkg::blsc_msg_s sensor_tx,
  output var  blsc_pkg::blsc_msg_s sensor_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  int pair_wait;
  initial
  begin
    busy = 1'b0;
    button = 1'b0;
    pair_done = 1'b0;
    sensor_rx = '0;
    pair_wait = 0;
  end
  always @(posedge mclk)
  begin
    if (go && !busy)
    begin
      #1;
      busy = 1'b1;
      if (hold)
      begin
        button = 1'b1;
        repeat (HOLD_LEN) @(posedge mclk);
        #1;
        button = 1'b0;
      end
      else
        repeat (n_press)
        begin
          // 6 cycles: past debounce, well inside the grouping window
          button = 1'b1;
          repeat (6) @(posedge mclk);
          #1;
          button = 1'b0;
          repeat (6) @(posedge mclk);
          #1;
        end
      busy = 1'b0;
    end
  end
  always @(posedge mclk)
  begin
    #1;
    if (!resetn)
      pair_wait = 0;
    else if (pair_start)
      pair_wait = 100;
    else if (pair_wait != 0)
      pair_wait = pair_wait - 1;
    pair_done = (pair_wait == 1);
    if (sensor_tx.req)
      sensor_rx = '{req: 1'b1, data: ~sensor_tx.data};
    else
      // idle word keeps changing so a stale copy cannot pass
      sensor_rx = '{req: 1'b0, data: ~sensor_rx.data};
  end
endmodule : blsc_far_model
`default_nettype wire

// [dv/test_button_led_state_control.sv]
// self-checking bench of the button and indicator state controller
`default_nettype none
module test_button_led_state_control import blsc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T_POFF = 200, T_HOLD = 50, T_PFL = 30, T_GROUP = 20, T_DEB = 2;
  localparam int T_FAST = 4, T_SLOW = 8, T_FLON = 3, T_GAP = 20;
  // one full group of flashes plus the dark gap
  localparam int PAIR_PER = 2 * T_FLON * PAIR_FLASHES + T_GAP;
  typedef struct packed {logic [3:0] np; logic link; blsc_state_e st; logic pwr;} blsc_row_s;
  logic mclk, resetn, button, host_link, charging, charge_full, pair_done, host_meas_req;
  logic go, hold, busy, led, power_en, unit_reset, meas_trigger, pair_start;
  logic [3:0] n_press;
  blsc_msg_s host_rx, sensor_rx, host_tx, sensor_tx;
  blsc_state_e state;
  int errors, cmp_count, hi, tg, n;
  blsc_row_s rows [11];

  blsc_ctrl #(.PAUSE_OFF_CYCLES(T_POFF), .HOLD_CYCLES(T_HOLD), .PFLASH_CYCLES(T_PFL), .GROUP_CYCLES(T_GROUP),
    .DEB_CYCLES(T_DEB), .FAST_CYCLES(T_FAST), .SLOW_CYCLES(T_SLOW), .FLON_CYCLES(T_FLON),
    .GAP_CYCLES(T_GAP)) u_dut (
    .mclk(mclk), .resetn(resetn), .button(button), .host_link(host_link), .charging(charging),
    .charge_full(charge_full), .pair_done(pair_done), .host_meas_req(host_meas_req),
    .host_rx(host_rx), .sensor_rx(sensor_rx), .led(led), .power_en(power_en),
    .unit_reset(unit_reset), .meas_trigger(meas_trigger), .pair_start(pair_start),
    .state(state), .host_tx(host_tx), .sensor_tx(sensor_tx));

  blsc_far_model u_far (
    .mclk(mclk), .resetn(resetn), .go(go), .n_press(n_press), .hold(hold), .busy(busy),
    .button(button), .pair_start(pair_start), .pair_done(pair_done),
    .sensor_tx(sensor_tx), .sensor_rx(sensor_rx));

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : cyc

  // counts reset pulses too, since the hold release lands inside the wait
  task automatic push(input logic [3:0] np, input logic h, output int r);
    int i;
    int t;
    r = 0;
    t = 0;
    n_press = np;
    hold = h;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    for (i = 0; i < 400 && t < T_GROUP + 5; i++)
    begin
      cyc(1);
      r += (unit_reset === 1'b1);
      t = (busy === 1'b1) ? 0 : t + 1;
    end
  endtask : push

  task automatic wait_st(input blsc_state_e e);
    int i;
    for (i = 0; i < 400 && state !== e; i++)
      cyc(1);
  endtask : wait_st

  task automatic led_stats(input int k, output int h, output int g);
    logic prev;
    h = 0;
    g = 0;
    prev = led;
    repeat (k)
    begin
      cyc(1);
      h += (led === 1'b1);
      g += (led !== prev);
      prev = led;
    end
  endtask : led_stats

  initial
  begin
    repeat (20000) @(posedge mclk);
    errors++;
    end_of_test();
  end

  initial
  begin
    {resetn, host_link, charging, charge_full, host_meas_req, go, hold} = '0;
    {errors, cmp_count} = '0;
    n_press = 4'h0;
    host_rx = '0;
    rows = '{'{4'h1, 1'b0, ST_SEARCH, 1'b1}, '{4'h0, 1'b1, ST_SWEEP, 1'b1},
      '{4'h1, 1'b1, ST_PAUSED, 1'b1}, '{4'h1, 1'b1, ST_SWEEP, 1'b1}, '{4'h0, 1'b0, ST_SEARCH, 1'b1},
      '{4'h0, 1'b1, ST_SWEEP, 1'b1}, '{4'h2, 1'b1, ST_SWEEP, 1'b1}, '{4'h4, 1'b1, ST_SWEEP, 1'b1},
      '{4'h5, 1'b1, ST_PAIR, 1'b1}, '{4'h0, 1'b1, ST_SWEEP, 1'b1}, '{4'h3, 1'b1, ST_OFF, 1'b0}};
    cyc(4);
    check(36'({state, led, power_en, unit_reset, meas_trigger, pair_start}), 36'h0);
    resetn = 1'b1;
    $display("reset test done");
    foreach (rows[k])
    begin
      host_link = rows[k].link;
      if (rows[k].np != 4'h0)
        push(rows[k].np, 1'b0, n);
      wait_st(rows[k].st);
      check(36'(state), 36'(rows[k].st));
      check(36'(power_en), 36'(rows[k].pwr));
    end
    $display("press table test done");
    host_link = 1'b0;
    push(4'h1, 1'b0, n);
    led_stats(40, hi, tg);
    check(36'(tg >= 4), 36'h1);
    host_link = 1'b1;
    wait_st(ST_SWEEP);
    led_stats(20, hi, tg);
    check(36'(hi), 36'h14);
    host_meas_req = 1'b1;
    cyc(1);
    host_meas_req = 1'b0;
    check(36'(meas_trigger), 36'h1);
    cyc(1);
    check(36'(meas_trigger), 36'h0);
    host_rx = '{req: 1'b1, data: 8'h5a};
    cyc(1);
    host_rx = '0;
    check(36'(sensor_tx), 36'h15a);
    cyc(1);
    check(36'(host_tx), 36'h1a5);
    $display("sweep test done");
    push(4'h1, 1'b0, n);
    host_meas_req = 1'b1;
    cyc(3);
    host_meas_req = 1'b0;
    check(36'(meas_trigger), 36'h0);
    led_stats(60, hi, tg);
    check(36'(hi > 0 && hi <= 12), 36'h1);
    check(36'(tg >= 2 && tg <= 6), 36'h1);
    cyc(90);
    check(36'(state), 36'(ST_PAUSED));
    wait_st(ST_OFF);
    cyc(2);
    check(36'({state, power_en}), 36'({ST_OFF, 1'b0}));
    $display("pause test done");
    host_link = 1'b0;
    push(4'h1, 1'b0, n);
    check(36'(state), 36'(ST_SEARCH));
    push(4'h0, 1'b1, n);
    check(36'(n), 36'h1);
    wait_st(ST_SEARCH);
    check(36'(power_en), 36'h1);
    $display("hold test done");
    push(4'h3, 1'b0, n);
    check(36'(state), 36'(ST_OFF));
    charging = 1'b1;
    wait_st(ST_CHARGE);
    check(36'(state), 36'(ST_CHARGE));
    led_stats(40, hi, tg);
    check(36'(tg >= 2), 36'h1);
    host_meas_req = 1'b1;
    cyc(2);
    host_meas_req = 1'b0;
    check(36'(meas_trigger), 36'h0);
    charge_full = 1'b1;
    cyc(10);
    led_stats(20, hi, tg);
    check(36'(hi), 36'h14);
    {charging, charge_full} = 2'h0;
    wait_st(ST_OFF);
    check(36'(state), 36'(ST_OFF));
    $display("charge test done");
    host_link = 1'b1;
    push(4'h1, 1'b0, n);
    wait_st(ST_SWEEP);
    push(4'h5, 1'b0, n);
    check(36'(state), 36'(ST_PAIR));
    led_stats(PAIR_PER, hi, tg);
    check(36'(hi), 36'(PAIR_FLASHES * T_FLON));
    check(36'(tg), 36'(2 * PAIR_FLASHES));
    wait_st(ST_SWEEP);
    check(36'(state), 36'(ST_SWEEP));
    $display("pairing test done");
    end_of_test();
  end
endmodule : test_button_led_state_control
`default_nettype wire
